// ===== ctl_far_side.sv
`timescale 1ns/1ns
module ctl_far_side (
  // Camera side of the general lines
  input  wire logic line_a_out_i,
  input  wire logic line_a_oe_i,
  input  wire logic line_b_out_i,
  input  wire logic line_b_oe_i,
  // Levels seen by the camera
  output logic      iso_in_o,
  output logic      line_a_in_o,
  output logic      line_b_in_o
);
  // Source level per line; bit 1 unused, that line only drives
  logic [3:0] lvl = 4'h0;

  // Source backs off while the camera drives a line
  assign iso_in_o    = lvl[0];
  assign line_a_in_o = line_a_oe_i ? line_a_out_i : lvl[2];
  assign line_b_in_o = line_b_oe_i ? line_b_out_i : lvl[3];

  // Caller sets pulse width, so short and slow sources both occur
  task automatic drive(input int ln, input logic v);
    lvl[ln] <= v;
  endtask
endmodule

// ===== ctl_pkg.sv
package ctl_pkg;

  // Time base
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRE_W         = 4;

  // Lines
  localparam int unsigned NLINES     = 4;
  localparam int unsigned LINE_ISO_I = 0;
  localparam int unsigned LINE_ISO_O = 1;
  localparam int unsigned LINE_GEN_A = 2;
  localparam int unsigned LINE_GEN_B = 3;

  // Limits and widths
  localparam int unsigned DEB_W       = 15;
  localparam int unsigned HOLD_W      = 23;
  localparam int unsigned DEB_MAX_US  = 20000;
  localparam int unsigned HOLD_MAX_US = 5000000;
  localparam int unsigned BURST_W     = 8;

  // Register offsets
  localparam logic [7:0] OFS_SEL    = 8'h00;
  localparam logic [7:0] OFS_DIR    = 8'h04;
  localparam logic [7:0] OFS_DEB    = 8'h08;
  localparam logic [7:0] OFS_ACT    = 8'h0C;
  localparam logic [7:0] OFS_HOLD   = 8'h10;
  localparam logic [7:0] OFS_SRC    = 8'h14;
  localparam logic [7:0] OFS_INFO   = 8'h18;
  localparam logic [7:0] OFS_USER   = 8'h1C;
  localparam logic [7:0] OFS_BURST  = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // Field positions
  localparam int unsigned INFO_OUT_BIT  = 0;
  localparam int unsigned INFO_OPTO_BIT = 1;
  localparam int unsigned STAT_RDY_BIT  = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;

  typedef enum logic [1:0] {ACT_RISE, ACT_FALL, ACT_HIGH, ACT_LOW} ctl_act_t;
  typedef enum logic [2:0] {SRC_READY, SRC_EXPOSURE, SRC_FLASH, SRC_USER, SRC_COUNTER,
                            SRC_TIMER} ctl_src_t;
  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_ARM, ST_READOUT} ctl_state_t;

  // Reset values
  localparam logic [1:0]         RST_SEL   = 2'h0;
  localparam logic [1:0]         RST_DIR   = 2'h0;
  localparam logic [DEB_W-1:0]   RST_DEB   = 15'h0000;
  localparam logic [HOLD_W-1:0]  RST_HOLD  = 23'h000000;
  localparam logic [3:0]         RST_USER  = 4'h0;
  localparam logic [BURST_W-1:0] RST_BURST = 8'h01;

endpackage

// ===== ctl_trigger_lines.sv
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns

module ctl_trigger_lines #(
  parameter int unsigned DEB_MAX_US  = ctl_pkg::DEB_MAX_US,
  parameter int unsigned HOLD_MAX_US = ctl_pkg::HOLD_MAX_US
) (
  // Clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Pins
  input  wire logic        iso_in_i,
  output logic             iso_out_o,
  input  wire logic        general_line_a_in_i,
  output logic             general_line_a_out_o,
  output logic             general_line_a_oe_o,
  input  wire logic        general_line_b_in_i,
  output logic             general_line_b_out_o,
  output logic             general_line_b_oe_o,
  // Capture engine
  input  wire logic        exposure_start_i,
  input  wire logic        exposure_active_i,
  input  wire logic        readout_done_i,
  input  wire logic        flash_i,
  input  wire logic        counter_pulse_i,
  input  wire logic        timer_pulse_i,
  output logic             capture_start_o,
  output logic             trigger_ready_o
);

  localparam int unsigned NL = ctl_pkg::NLINES;

  // Registers
  logic [1:0]                   sel;
  logic [1:0]                   dir;
  logic [ctl_pkg::DEB_W-1:0]    deb   [NL];
  logic [1:0]                   act   [NL];
  logic [ctl_pkg::HOLD_W-1:0]   hold  [NL];
  logic [2:0]                   src   [NL];
  logic [3:0]                   user_value;
  logic [ctl_pkg::BURST_W-1:0]  burst;

  // Time base, pins, filters
  logic [ctl_pkg::PRE_W-1:0]    pre_cnt;
  logic                         us_tick;
  logic [2:0]                   pin_meta;
  logic [2:0]                   pin_sync;
  logic [NL-1:0]                raw;
  logic [NL-1:0]                filt;
  logic [NL-1:0]                filt_d;
  logic [ctl_pkg::DEB_W-1:0]    deb_cnt [NL];
  logic [NL-1:0]                req;

  // Sequencer
  ctl_pkg::ctl_state_t          state;
  logic [ctl_pkg::HOLD_W-1:0]   hold_cnt;
  logic [ctl_pkg::HOLD_W-1:0]   hold_pick;
  logic [ctl_pkg::BURST_W-1:0]  frames;
  logic [NL-1:0]                drive;

  // Line properties
  wire [NL-1:0] is_out  = {dir[1], dir[0], 1'b1, 1'b0};
  wire [NL-1:0] is_opto = 4'h3;
  wire          sel_out = is_out[sel];

  // Bus decode
  wire        acc_go   = psel_i & penable_i & ~pready_o;
  wire        acc_done = psel_i & penable_i & pready_o;
  wire        wr       = acc_done & pwrite_i;
  wire        hit_sel  = paddr_i == ctl_pkg::OFS_SEL;
  wire        hit_dir  = paddr_i == ctl_pkg::OFS_DIR;
  wire        hit_deb  = paddr_i == ctl_pkg::OFS_DEB;
  wire        hit_act  = paddr_i == ctl_pkg::OFS_ACT;
  wire        hit_hold = paddr_i == ctl_pkg::OFS_HOLD;
  wire        hit_src  = paddr_i == ctl_pkg::OFS_SRC;
  wire        hit_info = paddr_i == ctl_pkg::OFS_INFO;
  wire        hit_user = paddr_i == ctl_pkg::OFS_USER;
  wire        hit_brst = paddr_i == ctl_pkg::OFS_BURST;
  wire        hit_stat = paddr_i == ctl_pkg::OFS_STATUS;
  wire        hit_any  = hit_sel | hit_dir | hit_deb | hit_act | hit_hold | hit_src
                       | hit_info | hit_user | hit_brst | hit_stat;
  wire        wr_in    = wr & ~sel_out;
  wire        wr_out   = wr & sel_out;

  // Clamp long intervals to their ceilings
  wire [ctl_pkg::DEB_W-1:0]  deb_wval  = (pwdata_i > 32'(DEB_MAX_US))
                                       ? ctl_pkg::DEB_W'(DEB_MAX_US)
                                       : pwdata_i[ctl_pkg::DEB_W-1:0];
  wire [ctl_pkg::HOLD_W-1:0] hold_wval = (pwdata_i > 32'(HOLD_MAX_US))
                                       ? ctl_pkg::HOLD_W'(HOLD_MAX_US)
                                       : pwdata_i[ctl_pkg::HOLD_W-1:0];

  wire        busy     = state != ctl_pkg::ST_IDLE;
  wire [31:0] info_val = {30'h0, is_opto[sel], sel_out};
  wire [31:0] stat_val = {30'h0, busy, trigger_ready_o};
  wire [31:0] rd_mux   = hit_sel  ? {30'h0, sel}
                       : hit_dir  ? {30'h0, dir}
                       : hit_deb  ? 32'(deb[sel])
                       : hit_act  ? {30'h0, act[sel]}
                       : hit_hold ? 32'(hold[sel])
                       : hit_src  ? {29'h0, src[sel]}
                       : hit_info ? info_val
                       : hit_user ? {28'h0000000, user_value}
                       : hit_brst ? 32'(burst)
                       : hit_stat ? stat_val
                       : 32'h00000000;

  // APB answer: one wait state on every access while ce_i is high
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pready_o  <= acc_go;
      prdata_o  <= (acc_go & ~pwrite_i) ? rd_mux : 32'h00000000;
      pslverr_o <= acc_go & ~hit_any;
    end
  end

  // Global registers
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sel        <= ctl_pkg::RST_SEL;
      dir        <= ctl_pkg::RST_DIR;
      user_value <= ctl_pkg::RST_USER;
      burst      <= ctl_pkg::RST_BURST;
    end
    else if (ce_i)
    begin
      if (wr & hit_sel)
        sel <= pwdata_i[1:0];
      if (wr & hit_dir)
        dir <= pwdata_i[1:0];
      if (wr & hit_user)
        user_value <= pwdata_i[3:0];
      if (wr & hit_brst & (pwdata_i[ctl_pkg::BURST_W-1:0] != '0))
        burst <= pwdata_i[ctl_pkg::BURST_W-1:0];
    end
  end

  // Microsecond tick
  assign us_tick = pre_cnt == ctl_pkg::PRE_W'(ctl_pkg::CYC_PER_US - 1);
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      pre_cnt <= '0;
    else if (ce_i)
      pre_cnt <= us_tick ? '0 : pre_cnt + 1'b1;
  end

  // Pin synchronisers
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end
    else if (ce_i)
    begin
      pin_meta <= {general_line_b_in_i, general_line_a_in_i, iso_in_i};
      pin_sync <= pin_meta;
    end
  end

  // Isolated output line has no input path
  assign raw = {pin_sync[2], pin_sync[1], 1'b0, pin_sync[0]};

  // Per-line settings, debounce filter and activation
  for (genvar i = 0; i < NL; i++)
  begin : g_line
    wire sel_me = sel == 2'(i);
    always_ff @(posedge clock_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        deb[i]  <= ctl_pkg::RST_DEB;
        act[i]  <= ctl_pkg::ACT_RISE;
        hold[i] <= ctl_pkg::RST_HOLD;
        src[i]  <= ctl_pkg::SRC_READY;
      end
      else if (ce_i)
      begin
        if (wr_in & hit_deb & sel_me)
          deb[i] <= deb_wval;
        if (wr_in & hit_act & sel_me)
          act[i] <= pwdata_i[1:0];
        if (wr_in & hit_hold & sel_me)
          hold[i] <= hold_wval;
        if (wr_out & hit_src & sel_me & (pwdata_i[2:0] <= 3'(ctl_pkg::SRC_TIMER)))
          src[i] <= pwdata_i[2:0];
      end
    end

    // Level must differ for more than the interval before it is taken
    always_ff @(posedge clock_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        filt[i]    <= 1'b0;
        filt_d[i]  <= 1'b0;
        deb_cnt[i] <= '0;
      end
      else if (ce_i)
      begin
        filt_d[i] <= filt[i];
        if (raw[i] == filt[i])
          deb_cnt[i] <= '0;
        else if (us_tick)
        begin
          if (deb_cnt[i] >= deb[i])
          begin
            filt[i]    <= raw[i];
            deb_cnt[i] <= '0;
          end
          else
            deb_cnt[i] <= deb_cnt[i] + 1'b1;
        end
      end
    end

    wire rise = filt[i] & ~filt_d[i];
    wire fall = ~filt[i] & filt_d[i];
    wire hit  = (act[i] == ctl_pkg::ACT_RISE) ? rise
              : (act[i] == ctl_pkg::ACT_FALL) ? fall
              : (act[i] == ctl_pkg::ACT_HIGH) ? filt[i]
              : ~filt[i];
    assign req[i] = hit & ~is_out[i];

    // Output source selection
    wire [3:0] pick = {user_value[i] & 1'b1, flash_i, exposure_active_i, trigger_ready_o};
    wire       val  = (src[i] == ctl_pkg::SRC_READY)    ? pick[0]
                    : (src[i] == ctl_pkg::SRC_EXPOSURE) ? pick[1]
                    : (src[i] == ctl_pkg::SRC_FLASH)    ? pick[2]
                    : (src[i] == ctl_pkg::SRC_USER)     ? pick[3]
                    : (src[i] == ctl_pkg::SRC_COUNTER)  ? counter_pulse_i
                    : timer_pulse_i;

    always_ff @(posedge clock_i or posedge reset_i)
    begin
      if (reset_i)
        drive[i] <= 1'b0;
      else if (ce_i)
        drive[i] <= val & is_out[i];
    end
  end

  // Lowest numbered requesting line supplies the holdoff
  always_comb
  begin
    hold_pick = '0;
    for (int k = NL - 1; k >= 0; k--)
    begin
      if (req[k])
        hold_pick = hold[k];
    end
  end

  wire last_frame = (frames + 1'b1) >= burst;
  // Trigger sequencer
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state           <= ctl_pkg::ST_IDLE;
      hold_cnt        <= '0;
      frames          <= '0;
      capture_start_o <= 1'b0;
      trigger_ready_o <= 1'b1;
    end
    else if (ce_i)
    begin
      capture_start_o <= 1'b0;
      if (exposure_start_i && state != ctl_pkg::ST_READOUT)
      begin
        trigger_ready_o <= 1'b0;
        frames          <= '0;
        state           <= ctl_pkg::ST_READOUT;
      end
      else
      begin
        case (state)
          ctl_pkg::ST_IDLE:
            if (|req & trigger_ready_o)
            begin
              hold_cnt <= hold_pick;
              state    <= ctl_pkg::ST_HOLD;
            end
          ctl_pkg::ST_HOLD:
            if (hold_cnt == '0)
            begin
              capture_start_o <= 1'b1;
              state           <= ctl_pkg::ST_ARM;
            end
            else if (us_tick)
              hold_cnt <= hold_cnt - 1'b1;
          ctl_pkg::ST_ARM:
            state <= ctl_pkg::ST_ARM;
          ctl_pkg::ST_READOUT:
            if (readout_done_i)
            begin
              if (last_frame)
              begin
                trigger_ready_o <= 1'b1;
                state           <= ctl_pkg::ST_IDLE;
              end
              else
                frames <= frames + 1'b1;
            end
          default:
            state <= ctl_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Pin drivers
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      iso_out_o            <= 1'b0;
      general_line_a_out_o <= 1'b0;
      general_line_a_oe_o  <= 1'b0;
      general_line_b_out_o <= 1'b0;
      general_line_b_oe_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      iso_out_o            <= drive[ctl_pkg::LINE_ISO_O];
      general_line_a_out_o <= drive[ctl_pkg::LINE_GEN_A];
      general_line_a_oe_o  <= dir[0];
      general_line_b_out_o <= drive[ctl_pkg::LINE_GEN_B];
      general_line_b_oe_o  <= dir[1];
    end
  end

endmodule

// ===== ctl_trigger_lines_assertions.sv
`timescale 1ns/1ns
module ctl_trigger_lines_assertions (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        ce_i,
  // Bus
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Pins and engine
  input wire logic        general_line_a_oe_o,
  input wire logic        exposure_start_i,
  input wire logic        readout_done_i,
  input wire logic        capture_start_o,
  input wire logic        trigger_ready_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);

  // Completed write to the direction register
  wire dir_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h04;

  sequence s_access;
    ce_i && psel_i && penable_i && !pready_o;
  endsequence
  sequence s_answer;
    pready_o ##1 !pready_o;
  endsequence

  property p_ready_answer;
    s_access |=> s_answer;
  endproperty
  property p_ready_cause;
    pready_o |-> $past(psel_i && penable_i);
  endproperty
  property p_idle_quiet;
    !pready_o |-> prdata_o == 32'h0 && !pslverr_o;
  endproperty
  property p_err_with_ready;
    pslverr_o |-> pready_o;
  endproperty
  property p_oe_by_write;
    $changed(general_line_a_oe_o) |-> $past(dir_wr) || $past(dir_wr, 2);
  endproperty
  property p_exp_drops_ready;
    ce_i && exposure_start_i |=> !trigger_ready_o;
  endproperty
  property p_fall_cause;
    $fell(trigger_ready_o) |-> $past(exposure_start_i);
  endproperty
  property p_rise_cause;
    $rose(trigger_ready_o) |-> $past(readout_done_i);
  endproperty
  property p_no_capture_busy;
    !trigger_ready_o |-> !capture_start_o;
  endproperty

  a_ready_answer: assert property (p_ready_answer) else $error("bus answer late");
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  a_idle_quiet: assert property (p_idle_quiet) else $error("bus outputs outside answer");
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  a_oe_by_write: assert property (p_oe_by_write) else $error("enable moved unasked");
  a_exp_drops_ready: assert property (p_exp_drops_ready) else $error("ready stays");
  a_fall_cause: assert property (p_fall_cause) else $error("ready fell unasked");
  a_rise_cause: assert property (p_rise_cause) else $error("ready rose early");
  a_no_capture_busy: assert property (p_no_capture_busy) else $error("capture busy");
endmodule

bind ctl_trigger_lines ctl_trigger_lines_assertions ctl_trigger_lines_assertions_inst (.*);

// ===== ctl_trigger_lines_test.sv
`timescale 1ns/1ns
module ctl_trigger_lines_test;
  // Stimulus
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        exposure_start_i = 1'b0;
  logic        exposure_active_i = 1'b0;
  logic        readout_done_i = 1'b0;
  logic        flash_i = 1'b0;
  logic        counter_pulse_i = 1'b0;
  logic        timer_pulse_i = 1'b0;
  // Design outputs and pins
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, iso_out_o, iso_in_i, capture_start_o, trigger_ready_o;
  logic        general_line_a_in_i, general_line_a_out_o, general_line_a_oe_o;
  logic        general_line_b_in_i, general_line_b_out_o, general_line_b_oe_o;
  // Bookkeeping
  int          bad_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          t, t0, t3;
  logic [31:0] r;
  logic        err;
  logic [39:0] rst_val = 40'h1102000000;
  logic [11:0] out_exp = 12'hB53;

  ctl_trigger_lines #(.DEB_MAX_US(20), .HOLD_MAX_US(50)) ctl_trigger_lines_inst (.*);
  ctl_far_side ctl_far_side_inst (
    .line_a_out_i (general_line_a_out_o),
    .line_a_oe_i  (general_line_a_oe_o),
    .line_b_out_i (general_line_b_out_o),
    .line_b_oe_i  (general_line_b_oe_o),
    .iso_in_o     (iso_in_i),
    .line_a_in_o  (general_line_a_in_i),
    .line_b_in_o  (general_line_b_in_i)
  );

  always #50 clock_i = ~clock_i;

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1 && n < 20)
    begin
      @(posedge clock_i);
      n++;
    end
    r = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
    chk("bus wait", 1, n < 20);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %0h", a), e, r);
  endtask

  task automatic wait_cap(input int n, output int c);
    c = 0;
    while (capture_start_o !== 1'b1 && c < n)
    begin
      @(posedge clock_i);
      c++;
    end
    @(posedge clock_i);
  endtask

  task automatic done_pulse;
    readout_done_i <= 1'b1;
    @(posedge clock_i);
    readout_done_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  // Exposure then n frames read out
  task automatic engine(input int n);
    exposure_start_i <= 1'b1;
    @(posedge clock_i);
    exposure_start_i <= 1'b0;
    @(posedge clock_i);
    repeat (n) done_pulse();
  endtask

  initial
  begin
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    for (int i = 0; i < 10; i++)
      rd(8'(i * 4), 32'(rst_val[i * 4 +: 4]));
    rd(8'h28, 32'h0);
    chk("pslverr", 1, err);
    wr(8'h18, 32'h0);
    rd(8'h18, 32'h2);
    $display("test registers done");
    wr(8'h00, 32'h1);
    rd(8'h18, 32'h3);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h1);
    rd(8'h18, 32'h1);
    chk("oe_a", 1, general_line_a_oe_o);
    chk("oe_b", 0, general_line_b_oe_o);
    wr(8'h08, 32'h5);
    rd(8'h08, 32'h0);
    wr(8'h14, 32'h3);
    wr(8'h1C, 32'h4);
    rd(8'h14, 32'h3);
    chk("line_a", 1, general_line_a_out_o);
    wr(8'h00, 32'h1);
    for (int p = 0; p < 2; p++)
    begin
      exposure_active_i <= !p;
      flash_i <= p;
      counter_pulse_i <= !p;
      timer_pulse_i <= p;
      wr(8'h1C, p ? 32'h6 : 32'h4);
      for (int s = 0; s < 6; s++)
      begin
        wr(8'h14, 32'(s));
        repeat (3) @(posedge clock_i);
        chk("iso_out", 32'(out_exp[p * 6 + s]), iso_out_o);
      end
    end
    wr(8'h04, 32'h3);
    repeat (20) @(posedge clock_i);
    chk("oe_b on", 1, general_line_b_oe_o);
    chk("line_b", 1, general_line_b_out_o);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h2);
    rd(8'h14, 32'h0);
    wr(8'h08, 32'd100);
    rd(8'h08, 32'd20);
    wr(8'h10, 32'd1000);
    rd(8'h10, 32'd50);
    wr(8'h20, 32'h0);
    rd(8'h20, 32'h1);
    $display("test outputs done");
    wr(8'h08, 32'h2);
    wr(8'h10, 32'h0);
    ctl_far_side_inst.drive(0, 1'b1);
    repeat (15) @(posedge clock_i);
    ctl_far_side_inst.drive(0, 1'b0);
    wait_cap(100, t);
    chk("short pulse", 100, t);
    ctl_far_side_inst.drive(0, 1'b1);
    wait_cap(200, t0);
    chk("rising", 1, t0 < 200);
    engine(1);
    ctl_far_side_inst.drive(0, 1'b0);
    wait_cap(100, t);
    chk("fall in rise mode", 100, t);
    wr(8'h0C, 32'h1);
    ctl_far_side_inst.drive(0, 1'b1);
    wait_cap(80, t);
    chk("rise in fall mode", 80, t);
    ctl_far_side_inst.drive(0, 1'b0);
    wait_cap(200, t);
    chk("falling", 1, t < 200);
    engine(1);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h3);
    wr(8'h20, 32'h2);
    ctl_far_side_inst.drive(0, 1'b1);
    wait_cap(300, t3);
    chk("holdoff", 1, t3 - t0 >= 20 && t3 - t0 <= 50);
    $display("test trigger done");
    engine(0);
    chk("ready at exposure", 0, trigger_ready_o);
    rd(8'h24, 32'h2);
    ctl_far_side_inst.drive(0, 1'b0);
    repeat (40) @(posedge clock_i);
    ctl_far_side_inst.drive(0, 1'b1);
    wait_cap(80, t);
    chk("busy trigger", 80, t);
    done_pulse();
    chk("ready first frame", 0, trigger_ready_o);
    done_pulse();
    chk("ready last frame", 1, trigger_ready_o);
    ctl_far_side_inst.drive(0, 1'b0);
    $display("test burst done");
    wr(8'h20, 32'h1);
    wr(8'h00, 32'h2);
    wr(8'h0C, 32'h2);
    ctl_far_side_inst.drive(2, 1'b1);
    wait_cap(200, t);
    chk("high level 1", 1, t < 200);
    engine(1);
    wait_cap(200, t);
    chk("high level 2", 1, t < 200);
    ctl_far_side_inst.drive(2, 1'b0);
    repeat (40) @(posedge clock_i);
    engine(1);
    wr(8'h00, 32'h3);
    wr(8'h0C, 32'h3);
    wait_cap(200, t);
    chk("low level", 1, t < 200);
    ctl_far_side_inst.drive(3, 1'b1);
    repeat (40) @(posedge clock_i);
    engine(1);
    wait_cap(100, t);
    chk("low level ended", 100, t);
    $display("test level done");
    summarize();
  end
endmodule
